// ===== src/fmp_pkg.sv
// Constants, types and register map of the fan and motor protection controller.
// Assumes a 100 MHz system clock and a parameter port addressed by sub-index.
package fmp_pkg;

    // ========================================================================
    // Register sub-indices
    localparam logic [7:0] OFS_FAN_MODE_SELECT = 8'h1B;
    localparam logic [7:0] OFS_FAN_ON_TEMPERATURE = 8'h1C;
    localparam logic [7:0] OFS_LOCK_ROTOR_PROTECT_ENABLE = 8'h23;
    localparam logic [7:0] OFS_OVERLOAD_COEFFICIENT = 8'h26;
    localparam logic [7:0] OFS_LOCK_ROTOR_DELAY = 8'h29;
    localparam logic [7:0] OFS_PARAMETER_COPY_SELECT = 8'h2D;
    localparam logic [7:0] OFS_FACTORY_REVERT_REQUEST = 8'h32;
    localparam logic [7:0] OFS_OVERHEAT_PROTECT_ENABLE = 8'h33;
    localparam logic [7:0] OFS_SENSOR_DISCONNECT_PROTECT_ENABLE = 8'h34;

    // ========================================================================
    // Reset values and legal ranges
    localparam logic [15:0] RST_FAN_MODE_SELECT = 16'h0002;
    localparam logic [15:0] RST_FAN_ON_TEMPERATURE = 16'h002D;
    localparam logic [15:0] RST_LOCK_ROTOR_PROTECT_ENABLE = 16'h0001;
    localparam logic [15:0] RST_OVERLOAD_COEFFICIENT = 16'h0064;
    localparam logic [15:0] RST_LOCK_ROTOR_DELAY = 16'h0064;
    localparam logic [15:0] RST_PARAMETER_COPY_SELECT = 16'h0000;
    localparam logic [15:0] RST_FACTORY_REVERT_REQUEST = 16'h0000;
    localparam logic [15:0] RST_OVERHEAT_PROTECT_ENABLE = 16'h0000;
    localparam logic [15:0] RST_SENSOR_DISCONNECT_PROTECT_ENABLE = 16'h0001;
    localparam logic [15:0] MAX_FAN_MODE = 16'h0002;
    localparam logic [15:0] MIN_FAN_TEMP = 16'h000A;
    localparam logic [15:0] MAX_FAN_TEMP = 16'h0064;
    localparam logic [15:0] MAX_FLAG = 16'h0001;
    localparam logic [15:0] MIN_COEF = 16'h0001;
    localparam logic [15:0] MAX_COEF = 16'h01F4;
    localparam logic [15:0] MIN_LOCK_DELAY = 16'h000A;
    localparam logic [15:0] MAX_LOCK_DELAY = 16'h03E8;

    // ========================================================================
    // Fan modes, temperatures in degrees Celsius and the full-scale percentage
    localparam logic [1:0] FAN_MODE_TEMP = 2'h0;
    localparam logic [1:0] FAN_MODE_ALWAYS = 2'h1;
    localparam logic [1:0] FAN_MODE_DRIVE = 2'h2;
    localparam logic [15:0] FAN_HYST_C = 16'h0005;
    localparam logic [15:0] DRIVE_FAN_HOT_C = 16'h002D;
    localparam logic [15:0] DRIVE_FAN_COOL_C = 16'h0028;
    localparam logic [15:0] PERCENT_FULL = 16'h0064;

    // ========================================================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS = 1000000;
    localparam int CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;
    localparam logic [15:0] FAN_RUNON_MS = 16'h01F4;
    localparam logic [15:0] KEY_HOLD_MS = 16'h01F4;
    localparam logic [15:0] REVERT_WAIT_MS = 16'h1388;
    localparam logic [15:0] LOCK_UNIT_MS = 16'h000A;

    // ========================================================================
    // Types
    typedef enum logic [1:0]
    {
        FMP_RV_IDLE = 2'b00,
        FMP_RV_HOLD = 2'b01,
        FMP_RV_SHOW = 2'b10
    } fmp_revert_e;

    typedef struct packed
    {
        logic [15:0] speed;
        logic [15:0] current;
    } fmp_motor_s;

    typedef struct packed
    {
        logic overload;
        logic lock_rotor;
        logic overheat;
        logic sensor_open;
    } fmp_fault_s;

endpackage : fmp_pkg

// ===== src/fmp_ms_tick.sv
// Millisecond enable generator for the protection controller.
// Assumes one free-running clock; the tick is a one-cycle enable pulse.
`timescale 1ns/1ps
module fmp_ms_tick #(
    parameter int CYCLES = fmp_pkg::CYCLES_PER_MS
) (
    input wire logic clk,
    input wire logic rst,
    output logic tick
);
    // ========================================================================
    // Divider
    logic [31:0] cnt;
    logic [31:0] next_cnt;
    logic next_tick;

    always_comb
    begin
        next_tick = 1'b0;
        next_cnt = cnt + 32'h00000001;
        if (cnt >= 32'(CYCLES - 1))
        begin
            next_cnt = 32'h00000000;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cnt <= 32'h00000000;
            tick <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            tick <= next_tick;
        end
    end
endmodule : fmp_ms_tick

// ===== src/fmp_ctrl.sv
// Fan control, factory revert and motor protection of a servo drive.
// Assumes synchronous inputs: radiator temperature in degrees, drive run
// state, motor speed and current, panel set key and motor sensor flags.
`timescale 1ns/1ps
module fmp_ctrl #(
    parameter int CYCLES_PER_MS = fmp_pkg::CYCLES_PER_MS,
    parameter logic [15:0] LOCK_SPEED_MAX = 16'h000A,
    parameter logic [15:0] LOCK_CURRENT_MIN = 16'h0200,
    parameter logic [15:0] RATED_CURRENT = 16'h0100,
    parameter logic [31:0] OVERLOAD_LIMIT = 32'h00100000
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] par_addr,
    input wire logic par_wr,
    input wire logic [15:0] par_wdata,
    input wire logic par_rd,
    output logic [15:0] par_rdata,
    output logic par_rvalid,
    output logic par_err,
    input wire logic [15:0] radiator_temp,
    input wire logic drive_running,
    input wire fmp_pkg::fmp_motor_s motor,
    input wire logic set_key,
    input wire logic motor_hot,
    input wire logic sensor_open,
    output logic fan_on,
    output logic display_zero,
    output logic revert_done,
    output fmp_pkg::fmp_fault_s fault
);
    // ========================================================================
    // Millisecond enable
    logic ms;

    fmp_ms_tick #(
        .CYCLES(CYCLES_PER_MS)
    ) u_tick (
        .clk(clk),
        .rst(rst),
        .tick(ms)
    );

    // ========================================================================
    // Parameter registers
    logic [15:0] fan_mode_select, fan_on_temperature, lock_rotor_protect_enable;
    logic [15:0] overload_coefficient, lock_rotor_delay, parameter_copy_select;
    logic [15:0] factory_revert_request, overheat_protect_enable;
    logic [15:0] sensor_disconnect_protect_enable;
    logic [15:0] next_fan_mode_select, next_fan_on_temperature;
    logic [15:0] next_lock_rotor_protect_enable, next_overload_coefficient;
    logic [15:0] next_lock_rotor_delay, next_parameter_copy_select;
    logic [15:0] next_factory_revert_request, next_overheat_protect_enable;
    logic [15:0] next_sensor_disconnect_protect_enable;
    logic [15:0] next_par_rdata;
    logic next_par_rvalid, next_par_err;
    logic restore;

    function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo,
                                      input logic [15:0] hi);
        in_range = (v >= lo) && (v <= hi);
    endfunction : in_range

    // Out-of-range writes are refused whole; only parameter_copy_select takes any value without a range check.
    always_comb
    begin
        next_fan_mode_select = fan_mode_select;
        next_fan_on_temperature = fan_on_temperature;
        next_lock_rotor_protect_enable = lock_rotor_protect_enable;
        next_overload_coefficient = overload_coefficient;
        next_lock_rotor_delay = lock_rotor_delay;
        next_parameter_copy_select = parameter_copy_select;
        next_factory_revert_request = factory_revert_request;
        next_overheat_protect_enable = overheat_protect_enable;
        next_sensor_disconnect_protect_enable = sensor_disconnect_protect_enable;
        next_par_rdata = 16'h0000;
        next_par_rvalid = par_rd;
        next_par_err = 1'b0;
        if (par_wr)
        begin
            next_par_err = 1'b1;
            case (par_addr)
                fmp_pkg::OFS_FAN_MODE_SELECT:
                    if (in_range(par_wdata, 16'h0000, fmp_pkg::MAX_FAN_MODE))
                    begin
                        next_fan_mode_select = par_wdata;
                        next_par_err = 1'b0;
                    end
                fmp_pkg::OFS_FAN_ON_TEMPERATURE:
                    if (in_range(par_wdata, fmp_pkg::MIN_FAN_TEMP, fmp_pkg::MAX_FAN_TEMP))
                    begin
                        next_fan_on_temperature = par_wdata;
                        next_par_err = 1'b0;
                    end
                fmp_pkg::OFS_LOCK_ROTOR_PROTECT_ENABLE:
                    if (in_range(par_wdata, 16'h0000, fmp_pkg::MAX_FLAG))
                    begin
                        next_lock_rotor_protect_enable = par_wdata;
                        next_par_err = 1'b0;
                    end
                fmp_pkg::OFS_OVERLOAD_COEFFICIENT:
                    if (in_range(par_wdata, fmp_pkg::MIN_COEF, fmp_pkg::MAX_COEF))
                    begin
                        next_overload_coefficient = par_wdata;
                        next_par_err = 1'b0;
                    end
                fmp_pkg::OFS_LOCK_ROTOR_DELAY:
                    if (in_range(par_wdata, fmp_pkg::MIN_LOCK_DELAY, fmp_pkg::MAX_LOCK_DELAY))
                    begin
                        next_lock_rotor_delay = par_wdata;
                        next_par_err = 1'b0;
                    end
                fmp_pkg::OFS_PARAMETER_COPY_SELECT:
                begin
                    next_parameter_copy_select = par_wdata;
                    next_par_err = 1'b0;
                end
                fmp_pkg::OFS_FACTORY_REVERT_REQUEST:
                    if (in_range(par_wdata, 16'h0000, fmp_pkg::MAX_FLAG))
                    begin
                        next_factory_revert_request = par_wdata;
                        next_par_err = 1'b0;
                    end
                fmp_pkg::OFS_OVERHEAT_PROTECT_ENABLE:
                    if (in_range(par_wdata, 16'h0000, fmp_pkg::MAX_FLAG))
                    begin
                        next_overheat_protect_enable = par_wdata;
                        next_par_err = 1'b0;
                    end
                fmp_pkg::OFS_SENSOR_DISCONNECT_PROTECT_ENABLE:
                    if (in_range(par_wdata, 16'h0000, fmp_pkg::MAX_FLAG))
                    begin
                        next_sensor_disconnect_protect_enable = par_wdata;
                        next_par_err = 1'b0;
                    end
                default:
                    next_par_err = 1'b1;
            endcase
        end
        if (par_rd)
        begin
            case (par_addr)
                fmp_pkg::OFS_FAN_MODE_SELECT: next_par_rdata = fan_mode_select;
                fmp_pkg::OFS_FAN_ON_TEMPERATURE: next_par_rdata = fan_on_temperature;
                fmp_pkg::OFS_LOCK_ROTOR_PROTECT_ENABLE:
                    next_par_rdata = lock_rotor_protect_enable;
                fmp_pkg::OFS_OVERLOAD_COEFFICIENT: next_par_rdata = overload_coefficient;
                fmp_pkg::OFS_LOCK_ROTOR_DELAY: next_par_rdata = lock_rotor_delay;
                fmp_pkg::OFS_PARAMETER_COPY_SELECT: next_par_rdata = parameter_copy_select;
                fmp_pkg::OFS_FACTORY_REVERT_REQUEST: next_par_rdata = factory_revert_request;
                fmp_pkg::OFS_OVERHEAT_PROTECT_ENABLE:
                    next_par_rdata = overheat_protect_enable;
                fmp_pkg::OFS_SENSOR_DISCONNECT_PROTECT_ENABLE:
                    next_par_rdata = sensor_disconnect_protect_enable;
                default:
                    next_par_err = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst || restore)
        begin
            fan_mode_select <= fmp_pkg::RST_FAN_MODE_SELECT;
            fan_on_temperature <= fmp_pkg::RST_FAN_ON_TEMPERATURE;
            lock_rotor_protect_enable <= fmp_pkg::RST_LOCK_ROTOR_PROTECT_ENABLE;
            overload_coefficient <= fmp_pkg::RST_OVERLOAD_COEFFICIENT;
            lock_rotor_delay <= fmp_pkg::RST_LOCK_ROTOR_DELAY;
            parameter_copy_select <= fmp_pkg::RST_PARAMETER_COPY_SELECT;
            factory_revert_request <= fmp_pkg::RST_FACTORY_REVERT_REQUEST;
            overheat_protect_enable <= fmp_pkg::RST_OVERHEAT_PROTECT_ENABLE;
            sensor_disconnect_protect_enable <= fmp_pkg::RST_SENSOR_DISCONNECT_PROTECT_ENABLE;
        end
        else
        begin
            fan_mode_select <= next_fan_mode_select;
            fan_on_temperature <= next_fan_on_temperature;
            lock_rotor_protect_enable <= next_lock_rotor_protect_enable;
            overload_coefficient <= next_overload_coefficient;
            lock_rotor_delay <= next_lock_rotor_delay;
            parameter_copy_select <= next_parameter_copy_select;
            factory_revert_request <= next_factory_revert_request;
            overheat_protect_enable <= next_overheat_protect_enable;
            sensor_disconnect_protect_enable <= next_sensor_disconnect_protect_enable;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            par_rdata <= 16'h0000;
            par_rvalid <= 1'b0;
            par_err <= 1'b0;
        end
        else
        begin
            par_rdata <= next_par_rdata;
            par_rvalid <= next_par_rvalid;
            par_err <= next_par_err;
        end
    end

    // ========================================================================
    // Fan and factory revert
    fmp_pkg::fmp_revert_e rv_state, next_rv_state;
    logic [15:0] rv_ms, next_rv_ms, runon_ms, next_runon_ms;
    logic hot_latch, next_hot_latch, next_fan_on, next_display_zero;
    logic drive_demand;

    always_comb
    begin
        next_rv_state = rv_state;
        next_rv_ms = rv_ms;
        next_display_zero = 1'b0;
        restore = 1'b0;
        case (rv_state)
            fmp_pkg::FMP_RV_IDLE:
            begin
                next_rv_ms = 16'h0000;
                if (set_key && factory_revert_request == 16'h0001)
                    next_rv_state = fmp_pkg::FMP_RV_HOLD;
            end
            fmp_pkg::FMP_RV_HOLD:
            begin
                if (!set_key || factory_revert_request != 16'h0001)
                    next_rv_state = fmp_pkg::FMP_RV_IDLE;
                else if (ms && rv_ms >= fmp_pkg::KEY_HOLD_MS - 16'h0001)
                begin
                    next_rv_state = fmp_pkg::FMP_RV_SHOW;
                    next_rv_ms = 16'h0000;
                    next_display_zero = 1'b1;
                end
                else if (ms)
                    next_rv_ms = rv_ms + 16'h0001;
            end
            fmp_pkg::FMP_RV_SHOW:
            begin
                next_display_zero = 1'b1;
                if (ms && rv_ms >= fmp_pkg::REVERT_WAIT_MS - 16'h0001)
                begin
                    restore = 1'b1;
                    next_display_zero = 1'b0;
                    next_rv_state = fmp_pkg::FMP_RV_IDLE;
                end
                else if (ms)
                    next_rv_ms = rv_ms + 16'h0001;
            end
            default:
                next_rv_state = fmp_pkg::FMP_RV_IDLE;
        endcase

        // Latch between 45 and 40 degrees keeps the fan from chattering near the limit.
        next_hot_latch = hot_latch;
        if (radiator_temp > fmp_pkg::DRIVE_FAN_HOT_C)
            next_hot_latch = 1'b1;
        else if (radiator_temp < fmp_pkg::DRIVE_FAN_COOL_C)
            next_hot_latch = 1'b0;
        drive_demand = drive_running || next_hot_latch;
        next_fan_on = fan_on;
        next_runon_ms = 16'h0000;
        case (fan_mode_select[1:0])
            fmp_pkg::FAN_MODE_TEMP:
                if (radiator_temp >= fan_on_temperature)
                    next_fan_on = 1'b1;
                else if (radiator_temp < fan_on_temperature - fmp_pkg::FAN_HYST_C)
                    next_fan_on = 1'b0;
            fmp_pkg::FAN_MODE_ALWAYS:
                next_fan_on = 1'b1;
            fmp_pkg::FAN_MODE_DRIVE:
                if (drive_demand)
                    next_fan_on = 1'b1;
                else if (fan_on)
                begin
                    next_runon_ms = runon_ms;
                    if (ms && runon_ms >= fmp_pkg::FAN_RUNON_MS - 16'h0001)
                        next_fan_on = 1'b0;
                    else if (ms)
                        next_runon_ms = runon_ms + 16'h0001;
                end
            default:
                next_fan_on = 1'b0;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rv_state <= fmp_pkg::FMP_RV_IDLE;
            rv_ms <= 16'h0000;
            hot_latch <= 1'b0;
            fan_on <= 1'b0;
            runon_ms <= 16'h0000;
            display_zero <= 1'b0;
            revert_done <= 1'b0;
        end
        else
        begin
            rv_state <= next_rv_state;
            rv_ms <= next_rv_ms;
            hot_latch <= next_hot_latch;
            fan_on <= next_fan_on;
            runon_ms <= next_runon_ms;
            display_zero <= next_display_zero;
            revert_done <= restore;
        end
    end

    // ========================================================================
    // Motor protection
    logic [31:0] heat, next_heat;
    logic [19:0] lock_ms, next_lock_ms;
    fmp_pkg::fmp_fault_s next_fault;
    logic [47:0] heat_scaled, limit_scaled;
    logic locked;

    always_comb
    begin
        next_heat = heat;
        if (ms && motor.current > RATED_CURRENT)
            next_heat = heat + 32'(motor.current - RATED_CURRENT);
        else if (ms && heat > 32'(RATED_CURRENT - motor.current))
            next_heat = heat - 32'(RATED_CURRENT - motor.current);
        else if (ms)
            next_heat = 32'h00000000;
        // Limit compared as heat*100 > limit*coef so that no divider is needed.
        heat_scaled = 48'(heat) * 48'(fmp_pkg::PERCENT_FULL);
        limit_scaled = 48'(OVERLOAD_LIMIT) * 48'(overload_coefficient);
        next_fault.overload = heat_scaled > limit_scaled;
        locked = lock_rotor_protect_enable[0] && motor.speed <= LOCK_SPEED_MAX
                 && motor.current >= LOCK_CURRENT_MIN;
        next_lock_ms = 20'h00000;
        if (locked)
            next_lock_ms = (ms && !fault.lock_rotor) ? lock_ms + 20'h00001 : lock_ms;
        next_fault.lock_rotor = locked
            && lock_ms >= 20'(lock_rotor_delay) * 20'(fmp_pkg::LOCK_UNIT_MS);
        next_fault.overheat = overheat_protect_enable[0] && motor_hot;
        next_fault.sensor_open = sensor_disconnect_protect_enable[0]
                                 && sensor_open;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            heat <= 32'h00000000;
            lock_ms <= 20'h00000;
            fault <= '0;
        end
        else
        begin
            heat <= next_heat;
            lock_ms <= next_lock_ms;
            fault <= next_fault;
        end
    end
endmodule : fmp_ctrl

// ===== dv/fmp_chk.sv
// Port checker of the fan and motor protection controller.
// Assumes a bind into fmp_ctrl and a millisecond tick of 10 clocks.
`timescale 1ns/1ps
module fmp_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] par_addr,
    input wire logic par_wr,
    input wire logic [15:0] par_wdata,
    input wire logic par_rd,
    input wire logic par_rvalid,
    input wire logic par_err,
    input wire logic [15:0] radiator_temp,
    input wire logic drive_running,
    input wire logic set_key,
    input wire logic motor_hot,
    input wire logic fan_on,
    input wire logic display_zero,
    input wire logic revert_done,
    input wire fmp_pkg::fmp_fault_s fault
);
    logic [1:0] hm;
    logic [15:0] ht;
    logic [15:0] idle_cnt, key_cnt;
    logic hl;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ========================================================================
    // Shadows
    // Idle time restarts on anything that may hold the mode 2 fan on.
    always_ff @(posedge clk)
    begin
        if (rst || revert_done)
        begin
            hm <= 2'h2;
            ht <= 16'h002D;
        end
        else if (par_wr && par_addr == 8'h1B && par_wdata <= 16'h0002)
            hm <= par_wdata[1:0];
        else if (par_wr && par_addr == 8'h1C && par_wdata inside {[16'h000A:16'h0064]})
            ht <= par_wdata;
        hl <= !rst && (radiator_temp > 16'h2D || hl && radiator_temp >= 16'h28);
        idle_cnt <= (rst || drive_running || hl || hm != 2'h2) ?
            16'h0000 : idle_cnt + {15'h0000, idle_cnt != 16'hFFFF};
        key_cnt <= (rst || !set_key) ? 16'h0000 : key_cnt + {15'h0000, key_cnt != 16'hFFFF};
    end
    // ========================================================================
    // Assertions
    rd_answer_a: assert property (par_rd |=> par_rvalid) else $error("read unanswered");
    rd_quiet_a: assert property (!par_rd |=> !par_rvalid) else $error("stray read valid");
    unmapped_err_a: assert property (par_rd && !(par_addr inside {8'h1B, 8'h1C, 8'h23, 8'h26,
        8'h29, 8'h2D, 8'h32, 8'h33, 8'h34}) |=> par_err) else $error("no error flag");
    mode1_fan_a: assert property (hm == 2'h1 [*3] |-> fan_on) else $error("fan off");
    mode0_on_a: assert property (hm == 2'h0 && radiator_temp >= ht |=> fan_on)
        else $error("fan not on at threshold");
    mode0_off_a: assert property (hm == 2'h0 && radiator_temp + 16'h0005 < ht
        |=> !fan_on) else $error("fan not off below band");
    drive_fan_a: assert property (hm == 2'h2 && drive_running |=> fan_on)
        else $error("fan off while running");
    runon_min_a: assert property (hm == 2'h2 && $fell(fan_on)
        |-> idle_cnt >= 16'h1374) else $error("run-on too short");
    runon_max_a: assert property (idle_cnt == 16'h13EC |-> !fan_on)
        else $error("run-on too long");
    revert_hold_a: assert property ($rose(display_zero) |-> key_cnt >= 16'h1374)
        else $error("revert without full key hold");
    revert_end_a: assert property ($fell(display_zero) |-> revert_done)
        else $error("display cleared without restore");
    overheat_gate_a: assert property (!motor_hot |=> !fault.overheat)
        else $error("overheat without cause");
    cover property ($rose(display_zero));
    cover property ($rose(fault.lock_rotor));
    cover property (hm == 2'h2 && $fell(fan_on));
endmodule : fmp_chk

bind fmp_ctrl fmp_chk chk_u (.*);

// ===== dv/fmp_plant.sv
// Far-side model: heatsink temperature and motor operating point.
// Assumes the bench gives a target temperature, speed and current.
`timescale 1ns/1ps
module fmp_plant (
    input wire logic clk,
    input wire logic [15:0] tgt,
    input wire logic [15:0] spd,
    input wire logic [15:0] cur,
    output logic [15:0] radiator_temp,
    output fmp_pkg::fmp_motor_s motor
);
    // The heatsink moves one degree a clock, so no threshold is jumped over.
    initial radiator_temp = 16'h0019;
    initial motor = '0;
    always @(posedge clk)
    begin
        radiator_temp <= radiator_temp + {15'h0000, tgt > radiator_temp}
            - {15'h0000, tgt < radiator_temp};
        motor <= '{speed: spd, current: cur};
    end
endmodule : fmp_plant

// ===== dv/test_fan_and_motor_protection_ctrl.sv
// Self-checking bench of the fan and motor protection controller.
// Assumes a 10-clock millisecond tick so all delays stay short.
`timescale 1ns/1ps
module test_fan_and_motor_protection_ctrl;
    logic clk, rst, par_wr, par_rd, par_rvalid, par_err, drive_running, set_key;
    logic motor_hot, sensor_open, fan_on, display_zero, revert_done;
    logic [7:0] par_addr;
    logic [15:0] par_wdata, par_rdata, radiator_temp, tgt, spd, cur, t;
    fmp_pkg::fmp_motor_s motor;
    fmp_pkg::fmp_fault_s fault;
    int bad_count, checked, cycles;
    logic [7:0] ofs [9] = '{8'h1B, 8'h1C, 8'h23, 8'h26, 8'h29, 8'h2D, 8'h32, 8'h33, 8'h34};
    logic [15:0] rstv [9] = '{16'h2, 16'h2D, 16'h1, 16'h64, 16'h64, 16'h0, 16'h0, 16'h0, 16'h1};
    fmp_ctrl #(.CYCLES_PER_MS(10)) dut_u (.*);
    fmp_plant plant_u (.*);
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ========================================================================
    // Tasks
    task automatic close_out;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic acc(input logic [7:0] a, input logic wr, input logic [15:0] d,
        input logic err, input logic [15:0] exp);
        @(posedge clk);
        par_addr <= a;
        par_wr <= wr;
        par_rd <= !wr;
        par_wdata <= d;
        @(posedge clk);
        par_wr <= 1'b0;
        par_rd <= 1'b0;
        #1;
        cmp(16'(par_err), 16'(err));
        if (!wr)
            cmp(par_rdata, exp);
    endtask : acc
    task automatic heat(input logic [15:0] v);
        @(posedge clk);
        tgt <= v;
        cyc(100);
    endtask : heat
    // ========================================================================
    // Timeout: the plan needs about 68000 clocks.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 80000)
        begin
            bad_count++;
            close_out();
        end
    end
    initial
    begin
        {par_addr, par_wr, par_wdata, par_rd, drive_running, set_key, motor_hot, sensor_open} = '0;
        {tgt, spd, cur} = {16'h0019, 16'h0100, 16'h0000};
        rst = 1'b1;
        void'($urandom(32'h7aa1));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        foreach (ofs[i]) acc(ofs[i], 1'b0, 16'h0, 1'b0, rstv[i]);
        acc(8'h00, 1'b0, 16'h0, 1'b1, 16'h0);
        acc(8'h1B, 1'b1, 16'h3, 1'b1, 16'h0);
        acc(8'h1B, 1'b0, 16'h0, 1'b0, 16'h2);
        acc(8'h26, 1'b1, 16'h1F5, 1'b1, 16'h0);
        acc(8'h29, 1'b1, 16'h9, 1'b1, 16'h0);
        repeat (4)
        begin
            t = 16'h000A + 16'($urandom % 91);
            acc(8'h1C, 1'b1, t, 1'b0, 16'h0);
            acc(8'h1C, 1'b0, 16'h0, 1'b0, t);
        end
        acc(8'h1B, 1'b1, 16'h1, 1'b0, 16'h0);
        cyc(3);
        cmp(fan_on, 1'b1);
        acc(8'h1C, 1'b1, 16'h3C, 1'b0, 16'h0);
        acc(8'h1B, 1'b1, 16'h0, 1'b0, 16'h0);
        cyc(3);
        cmp(fan_on, 1'b0);
        heat(16'h3C);
        cmp(fan_on, 1'b1);
        heat(16'h37);
        cmp(fan_on, 1'b1);
        heat(16'h36);
        cmp(fan_on, 1'b0);
        heat(16'h1E);
        acc(8'h1B, 1'b1, 16'h2, 1'b0, 16'h0);
        @(posedge clk);
        drive_running <= 1'b1;
        cyc(3);
        cmp(fan_on, 1'b1);
        @(posedge clk);
        drive_running <= 1'b0;
        cyc(4900);
        cmp(fan_on, 1'b1);
        cyc(200);
        cmp(fan_on, 1'b0);
        heat(16'h32);
        cmp(fan_on, 1'b1);
        heat(16'h1E);
        cyc(5100);
        cmp(fan_on, 1'b0);
        acc(8'h26, 1'b1, 16'h1, 1'b0, 16'h0);
        @(posedge clk);
        cur <= 16'h0200;
        cyc(350);
        cmp(fault.overload, 1'b0);
        cyc(150);
        cmp(fault.overload, 1'b1);
        @(posedge clk);
        cur <= 16'h0000;
        cyc(600);
        cmp(fault.overload, 1'b0);
        acc(8'h26, 1'b1, 16'h64, 1'b0, 16'h0);
        acc(8'h29, 1'b1, 16'hA, 1'b0, 16'h0);
        @(posedge clk);
        {spd, cur} <= {16'h0000, 16'h0200 + 16'($urandom % 256)};
        cyc(950);
        cmp(fault.lock_rotor, 1'b0);
        cyc(100);
        cmp(fault.lock_rotor, 1'b1);
        acc(8'h23, 1'b1, 16'h0, 1'b0, 16'h0);
        cyc(2);
        cmp(fault.lock_rotor, 1'b0);
        @(posedge clk);
        {spd, cur, motor_hot, sensor_open} <= {16'h0100, 16'h0000, 2'b11};
        cyc(3);
        cmp(fault.overheat, 1'b0);
        cmp(fault.sensor_open, 1'b1);
        acc(8'h33, 1'b1, 16'h1, 1'b0, 16'h0);
        acc(8'h34, 1'b1, 16'h0, 1'b0, 16'h0);
        cyc(2);
        cmp(fault.overheat, 1'b1);
        cmp(fault.sensor_open, 1'b0);
        acc(8'h1B, 1'b1, 16'h0, 1'b0, 16'h0);
        acc(8'h32, 1'b1, 16'h1, 1'b0, 16'h0);
        @(posedge clk);
        set_key <= 1'b1;
        cyc(4900);
        cmp(display_zero, 1'b0);
        cyc(200);
        cmp(display_zero, 1'b1);
        @(posedge clk);
        set_key <= 1'b0;
        cyc(49700);
        cmp(display_zero, 1'b1);
        for (int n = 0; n < 400 && revert_done !== 1'b1; n++) cyc(1);
        cmp(revert_done, 1'b1);
        cyc(1);
        cmp(display_zero, 1'b0);
        acc(8'h1B, 1'b0, 16'h0, 1'b0, 16'h2);
        acc(8'h33, 1'b0, 16'h0, 1'b0, 16'h0);
        close_out();
    end
endmodule : test_fan_and_motor_protection_ctrl
